// ---- core/dtc_pkg.sv ----
// constants, field positions and types shared by the dual timer/counter block
// How it works
// [RULE1] timer one overflow sets its flag; vector clears
// [RULE2] timer zero overflow sets its flag; vector clears
// [RULE3] timer one runs while its run bit set
// [RULE4] timer zero runs while its run bit set
// [RULE5] input one pending on selected edge/level
// [RULE6] input zero pending on selected edge/level
// [RULE7] input one type bit: 0 level, 1 edge
// [RULE8] input zero type bit: 0 level, 1 edge
// [RULE9] timer one gate needs input one active
// [RULE10] timer zero gate needs input zero active
// [RULE11] timer one counts pin falls or internal clock
// [RULE12] timer zero counts pin falls or internal clock
// [RULE13] timer one modes: 13, 16, 8-reload, inactive
// [RULE14] timer zero modes: 13, 16, 8-reload, split
// [RULE15] timer zero low byte readable and writable
// [RULE16] timer one low byte readable and writable
// [RULE17] timer zero high byte readable and writable
// [RULE18] control register bits singly read and writable
// [RULE19] 13-bit mode: high byte plus five bits
// [RULE20] 8-bit mode reloads low from high byte
// [RULE21] split: high byte uses run one, flag one
// [RULE22] prescale: div 12, 4, 48, ext div 8
// [RULE23] hardware set beats software clear same cycle
package dtc_pkg;
	// ---------------------------------------------------------------
	// register addresses and reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_RUN_FLAGS = 8'h88;
	localparam logic [7:0] ADDR_MODE_CFG  = 8'h89;
	localparam logic [7:0] ADDR_T0_LOW    = 8'h8A;
	localparam logic [7:0] ADDR_T1_LOW    = 8'h8B;
	localparam logic [7:0] ADDR_T0_HIGH   = 8'h8C;
	localparam logic [7:0] ADDR_T1_HIGH   = 8'h8D;
	localparam logic [7:0] RESET_BYTE     = 8'h00;
	localparam logic [7:0] BYTE_ONES      = 8'hFF;
	localparam logic [12:0] COUNT13_MAX   = 13'h1FFF;
	// ---------------------------------------------------------------
	// bit positions
	// ---------------------------------------------------------------
	localparam int BIT_TF1 = 7;
	localparam int BIT_TR1 = 6;
	localparam int BIT_TF0 = 5;
	localparam int BIT_TR0 = 4;
	localparam int BIT_IE1 = 3;
	localparam int BIT_IT1 = 2;
	localparam int BIT_IE0 = 1;
	localparam int BIT_IT0 = 0;
	localparam int BIT_TIMER_ONE_GATING = 7;
	localparam int BIT_CT1   = 6;
	localparam int MODE1_LSB = 4;
	localparam int BIT_TIMER_ZERO_GATING = 3;
	localparam int BIT_CT0   = 2;
	localparam int MODE0_LSB = 0;
	// synchroniser lanes
	localparam int PIN_EXT_IRQ_ZERO_INPUT = 0;
	localparam int PIN_EXT_IRQ_ONE_INPUT = 1;
	localparam int PIN_T0   = 2;
	localparam int PIN_T1   = 3;
	localparam int PIN_EXT  = 4;
	localparam int NPINS    = 5;
	// ---------------------------------------------------------------
	// modes and prescaler
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		DTC_MODE13,
		DTC_MODE16,
		DTC_MODE8AR,
		DTC_MODE_SPLIT
	} dtc_mode_e;
	localparam logic [1:0] PRE_DIV12 = 2'h0;
	localparam logic [1:0] PRE_DIV4  = 2'h1;
	localparam logic [1:0] PRE_DIV48 = 2'h2;
	localparam logic [1:0] PRE_EXT8  = 2'h3;
	localparam int DIV_12 = 12;
	localparam int DIV_4  = 4;
	localparam int DIV_48 = 48;
	localparam int DIV_8  = 8;
endpackage : dtc_pkg

// ---- core/dtc_presc_if.sv ----
// prescaler hookup between timer core and prescaler
interface dtc_presc_if;
	logic [1:0] sel;
	logic       ext_fall;
	logic       tick;
	modport ctrl  (output sel, output ext_fall, input tick);
	modport presc (input sel, input ext_fall, output tick);
endinterface : dtc_presc_if

// ---- core/dtc_prescaler.sv ----
// shared timer clock prescaler
module dtc_prescaler
	import dtc_pkg::*;
#(
	parameter int DIV_A = DIV_12,
	parameter int DIV_B = DIV_4,
	parameter int DIV_C = DIV_48,
	parameter int DIV_E = DIV_8,
	parameter int CW    = 6
) (
	input wire logic     clk,
	input wire logic     resetn,
	input wire logic     ce,
	dtc_presc_if.presc   pif
);
	if (DIV_A < 1 || DIV_B < 1 || DIV_C < 1 || DIV_E < 1) begin : g_chk_min
		$error("prescaler divisors must be at least one");
	end
	if (DIV_A > 2**CW || DIV_B > 2**CW || DIV_C > 2**CW || DIV_E > 2**CW) begin : g_chk_w
		$error("prescaler counter too narrow for a divisor");
	end

	logic [CW-1:0] cnt;
	logic [CW-1:0] limit;
	logic          step;
	logic          last;

	// RULE22: the external choice counts synchronised falling edges, not cycles
	assign limit = (pif.sel == PRE_DIV12) ? CW'(DIV_A - 1) :
		(pif.sel == PRE_DIV4) ? CW'(DIV_B - 1) :
		(pif.sel == PRE_DIV48) ? CW'(DIV_C - 1) : CW'(DIV_E - 1); // [RULE22]
	assign step = (pif.sel == PRE_EXT8) ? pif.ext_fall : 1'b1;
	// a lowered divisor below the count still wraps at once
	assign last = (cnt >= limit);
	assign pif.tick = ce & step & last; // [RULE22]

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt <= '0;
		end else if (ce && step) begin
			cnt <= last ? '0 : cnt + CW'(1);
		end
	end
endmodule : dtc_prescaler

// ---- core/dtc_timer_core.sv ----
// dual timer/counter with external interrupt flags, top module
module dtc_timer_core
	import dtc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       ce,
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	input  wire logic [7:0] sfr_wdata,
	input  wire logic       sfr_bit_wr,
	input  wire logic [2:0] sfr_bit_sel,
	input  wire logic       sfr_bit_val,
	output logic [7:0]      sfr_rdata,
	input  wire logic       vec_ack_tf0,
	input  wire logic       vec_ack_tf1,
	input  wire logic       vec_ack_ie0,
	input  wire logic       vec_ack_ie1,
	input  wire logic       ext_irq_zero_input,
	input  wire logic       ext_irq_one_input,
	input  wire logic       count_pin_zero,
	input  wire logic       count_pin_one,
	input  wire logic       ext_clk_pin,
	input  wire logic       ext_irq_zero_polarity,
	input  wire logic       ext_irq_one_polarity,
	input  wire logic [1:0] prescale_select,
	input  wire logic       t0_sysclk_sel,
	input  wire logic       t1_sysclk_sel,
	output logic            timer_zero_overflow_flag,
	output logic            timer_one_overflow_flag,
	output logic            ext_irq_zero_pending,
	output logic            ext_irq_one_pending,
	output logic            timer_one_overflow_pulse
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [7:0]       timer_run_and_flags_control;
	logic [7:0]       timer_mode_config;
	logic [7:0]       tl0;
	logic [7:0]       th0;
	logic [7:0]       tl1;
	logic [7:0]       th1;
	logic [NPINS-1:0] sy1;
	logic [NPINS-1:0] sy2;
	logic [NPINS-1:0] sy3;
	logic [NPINS-1:0] lvl;
	logic             sync_ok;
	logic             act0_q;
	logic             act1_q;

	// ---------------------------------------------------------------
	// timer step, shared by both timers: returns {overflow, high, low}
	// ---------------------------------------------------------------
	function automatic logic [16:0] tstep(input logic [1:0] mode, input logic [15:0] cnt);
		logic [12:0] c13;
		logic [12:0] n13;
		logic        ovf;
		logic [15:0] n;
		c13 = {cnt[15:8], cnt[4:0]};
		n13 = c13 + 13'h0001;
		ovf = 1'b0;
		n   = cnt;
		case (dtc_mode_e'(mode))
			DTC_MODE13: begin
				// upper three low-byte bits are left alone
				ovf = (c13 == COUNT13_MAX); // [RULE19]
				n   = {n13[12:5], cnt[7:5], n13[4:0]}; // [RULE19]
			end
			DTC_MODE16: begin
				{ovf, n} = {1'b0, cnt} + 17'h00001;
			end
			DTC_MODE8AR: begin
				ovf = (cnt[7:0] == BYTE_ONES); // [RULE20]
				n   = {cnt[15:8], ovf ? cnt[15:8] : cnt[7:0] + 8'h01}; // [RULE20]
			end
			default: begin
				ovf = 1'b0;
				n   = cnt;
			end
		endcase
		return {ovf, n};
	endfunction : tstep

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	// a lane's level moves only once the last two stages agree, which
	// filters a one-cycle glitch caught on the boundary
	wire [NPINS-1:0] pins = {ext_clk_pin, count_pin_one, count_pin_zero,
		ext_irq_one_input, ext_irq_zero_input};
	wire [NPINS-1:0] agree    = ~(sy2 ^ sy3);
	wire [NPINS-1:0] next_lvl = (agree & sy3) | (~agree & lvl);
	wire [NPINS-1:0] fall     = {NPINS{sync_ok}} & lvl & ~next_lvl;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sy1     <= '0;
			sy2     <= '0;
			sy3     <= '0;
			lvl     <= '0;
			sync_ok <= 1'b0;
		end else if (ce) begin
			sy1     <= pins;
			sy2     <= sy1;
			sy3     <= sy2;
			lvl     <= next_lvl;
			sync_ok <= sync_ok | (&agree);
		end
	end

	// ---------------------------------------------------------------
	// prescaler
	// ---------------------------------------------------------------
	dtc_presc_if pif ();
	assign pif.sel      = prescale_select;
	assign pif.ext_fall = fall[PIN_EXT];

	dtc_prescaler u_presc (
		.clk    (clk),
		.resetn (resetn),
		.ce     (ce),
		.pif    (pif)
	);

	// ---------------------------------------------------------------
	// field decode
	// ---------------------------------------------------------------
	wire       tr0   = timer_run_and_flags_control[BIT_TR0];
	wire       tr1   = timer_run_and_flags_control[BIT_TR1];
	wire       it0   = timer_run_and_flags_control[BIT_IT0];
	wire       it1   = timer_run_and_flags_control[BIT_IT1];
	wire       timer_zero_gating = timer_mode_config[BIT_TIMER_ZERO_GATING];
	wire       timer_one_gating = timer_mode_config[BIT_TIMER_ONE_GATING];
	wire       ct0   = timer_mode_config[BIT_CT0];
	wire       ct1   = timer_mode_config[BIT_CT1];
	wire [1:0] mode0 = timer_mode_config[MODE0_LSB +: 2];
	wire [1:0] mode1 = timer_mode_config[MODE1_LSB +: 2];
	wire       split = (mode0 == DTC_MODE_SPLIT);

	// ---------------------------------------------------------------
	// external interrupt inputs
	// ---------------------------------------------------------------
	// polarity 1 means active high; nothing counts until lanes settle
	wire act0  = sync_ok & (lvl[PIN_EXT_IRQ_ZERO_INPUT] == ext_irq_zero_polarity);
	wire act1  = sync_ok & (lvl[PIN_EXT_IRQ_ONE_INPUT] == ext_irq_one_polarity);
	wire edge0 = act0 & ~act0_q;
	wire edge1 = act1 & ~act1_q;
	wire set_ie0 = it0 ? edge0 : act0; // [RULE8] [RULE6]
	wire set_ie1 = it1 ? edge1 : act1; // [RULE7] [RULE5]

	// ---------------------------------------------------------------
	// timer zero
	// ---------------------------------------------------------------
	wire t0_int  = t0_sysclk_sel | pif.tick;
	wire t0_tick = ct0 ? fall[PIN_T0] : t0_int; // [RULE12]
	wire t0_run  = tr0 & (~timer_zero_gating | act0); // [RULE4] [RULE10]
	wire t0_adv  = t0_run & t0_tick;
	wire [16:0] t0_res = tstep(mode0, {th0, tl0}); // [RULE14]
	// split: low byte keeps timer zero controls, high byte borrows run one
	wire tl0_ovf = (tl0 == BYTE_ONES);
	wire th0_adv = split & tr1 & t0_int; // [RULE21]
	wire th0_ovf = th0_adv & (th0 == BYTE_ONES); // [RULE21]
	wire set_tf0 = t0_adv & (split ? tl0_ovf : t0_res[16]); // [RULE2]

	// ---------------------------------------------------------------
	// timer one
	// ---------------------------------------------------------------
	// while timer zero is split, timer one runs purely by its mode and
	// may not use its pin nor touch its flag; its overflow still pulses
	wire t1_int  = t1_sysclk_sel | pif.tick;
	wire t1_tick = (ct1 & ~split) ? fall[PIN_T1] : t1_int; // [RULE11]
	wire t1_live = (mode1 != DTC_MODE_SPLIT); // [RULE13]
	wire t1_run  = t1_live & (split | (tr1 & (~timer_one_gating | act1))); // [RULE3] [RULE9]
	wire t1_adv  = t1_run & t1_tick;
	wire [16:0] t1_res = tstep(mode1, {th1, tl1}); // [RULE13]
	wire t1_ovf  = t1_adv & t1_res[16];
	wire set_tf1 = split ? th0_ovf : t1_ovf; // [RULE1] [RULE21]

	// ---------------------------------------------------------------
	// register write decode
	// ---------------------------------------------------------------
	wire wr_timer_run_and_flags_control = sfr_wr & (sfr_addr == ADDR_RUN_FLAGS);
	wire wr_timer_mode_config = sfr_wr & (sfr_addr == ADDR_MODE_CFG);
	wire wr_tl0  = sfr_wr & (sfr_addr == ADDR_T0_LOW); // [RULE15]
	wire wr_tl1  = sfr_wr & (sfr_addr == ADDR_T1_LOW); // [RULE16]
	wire wr_th0  = sfr_wr & (sfr_addr == ADDR_T0_HIGH); // [RULE17]
	wire wr_th1  = sfr_wr & (sfr_addr == ADDR_T1_HIGH);

	// ---------------------------------------------------------------
	// control register next value
	// ---------------------------------------------------------------
	logic [7:0] next_timer_run_and_flags_control;
	always_comb begin
		next_timer_run_and_flags_control = timer_run_and_flags_control;
		if (wr_timer_run_and_flags_control) begin
			next_timer_run_and_flags_control = sfr_wdata;
		end
		if (sfr_bit_wr) begin
			next_timer_run_and_flags_control[sfr_bit_sel] = sfr_bit_val; // [RULE18]
		end
		if (vec_ack_tf0) begin
			next_timer_run_and_flags_control[BIT_TF0] = 1'b0; // [RULE2]
		end
		if (vec_ack_tf1) begin
			next_timer_run_and_flags_control[BIT_TF1] = 1'b0; // [RULE1]
		end
		// a level-mode pending flag is set every cycle the pin is active and stays set until software clears it, so vectoring leaves it
		if (vec_ack_ie0 && it0) begin
			next_timer_run_and_flags_control[BIT_IE0] = 1'b0; // [RULE6]
		end
		if (vec_ack_ie1 && it1) begin
			next_timer_run_and_flags_control[BIT_IE1] = 1'b0; // [RULE5]
		end
		// hardware sets are applied last so they win over any clear
		next_timer_run_and_flags_control[BIT_TF0] = next_timer_run_and_flags_control[BIT_TF0] | set_tf0; // [RULE23]
		next_timer_run_and_flags_control[BIT_TF1] = next_timer_run_and_flags_control[BIT_TF1] | set_tf1; // [RULE23]
		next_timer_run_and_flags_control[BIT_IE0] = next_timer_run_and_flags_control[BIT_IE0] | set_ie0; // [RULE23]
		next_timer_run_and_flags_control[BIT_IE1] = next_timer_run_and_flags_control[BIT_IE1] | set_ie1; // [RULE23]
	end

	// ---------------------------------------------------------------
	// count register next values
	// ---------------------------------------------------------------
	// a software byte write beats a count on the same edge
	logic [7:0] next_tl0;
	logic [7:0] next_th0;
	logic [7:0] next_tl1;
	logic [7:0] next_th1;
	always_comb begin
		next_tl0 = tl0;
		next_th0 = th0;
		if (split) begin
			if (t0_adv) begin
				next_tl0 = tl0 + 8'h01;
			end
			if (th0_adv) begin
				next_th0 = th0 + 8'h01;
			end
		end else if (t0_adv) begin
			{next_th0, next_tl0} = t0_res[15:0];
		end
		if (wr_tl0) begin
			next_tl0 = sfr_wdata; // [RULE15]
		end
		if (wr_th0) begin
			next_th0 = sfr_wdata; // [RULE17]
		end
	end

	always_comb begin
		next_tl1 = tl1;
		next_th1 = th1;
		if (t1_adv) begin
			{next_th1, next_tl1} = t1_res[15:0];
		end
		if (wr_tl1) begin
			next_tl1 = sfr_wdata; // [RULE16]
		end
		if (wr_th1) begin
			next_th1 = sfr_wdata;
		end
	end

	// ---------------------------------------------------------------
	// read mux
	// ---------------------------------------------------------------
	// unmapped addresses read zero
	wire [7:0] rd_mux =
		(sfr_addr == ADDR_RUN_FLAGS) ? timer_run_and_flags_control :
		(sfr_addr == ADDR_MODE_CFG)  ? timer_mode_config :
		(sfr_addr == ADDR_T0_LOW)    ? tl0 :
		(sfr_addr == ADDR_T1_LOW)    ? tl1 :
		(sfr_addr == ADDR_T0_HIGH)   ? th0 :
		(sfr_addr == ADDR_T1_HIGH)   ? th1 : RESET_BYTE;

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			timer_run_and_flags_control <= RESET_BYTE;
			timer_mode_config <= RESET_BYTE;
		end else if (ce) begin
			timer_run_and_flags_control <= next_timer_run_and_flags_control; // [RULE18]
			if (wr_timer_mode_config) begin
				timer_mode_config <= sfr_wdata;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tl0 <= RESET_BYTE;
			th0 <= RESET_BYTE;
			tl1 <= RESET_BYTE;
			th1 <= RESET_BYTE;
		end else if (ce) begin
			tl0 <= next_tl0;
			th0 <= next_th0;
			tl1 <= next_tl1;
			th1 <= next_th1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			act0_q <= 1'b0;
			act1_q <= 1'b0;
		end else if (ce) begin
			act0_q <= act0;
			act1_q <= act1;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	// the pulse serves baud and trigger users even while the flag is
	// owned by the split high byte
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sfr_rdata                <= RESET_BYTE;
			timer_one_overflow_pulse <= 1'b0;
		end else if (ce) begin
			if (sfr_rd) begin
				sfr_rdata <= rd_mux;
			end
			timer_one_overflow_pulse <= t1_ovf;
		end
	end

	assign timer_zero_overflow_flag = timer_run_and_flags_control[BIT_TF0];
	assign timer_one_overflow_flag  = timer_run_and_flags_control[BIT_TF1];
	assign ext_irq_zero_pending     = timer_run_and_flags_control[BIT_IE0];
	assign ext_irq_one_pending      = timer_run_and_flags_control[BIT_IE1];
endmodule : dtc_timer_core

// ---- bench/dtc_timer_core_asserts.sv ----
// port-level assertions for the dual timer/counter block
module dtc_timer_core_asserts (
	input wire logic       clk,
	input wire logic       resetn,
	input wire logic       ce,
	input wire logic [7:0] sfr_addr,
	input wire logic       sfr_wr,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_wdata,
	input wire logic       sfr_bit_wr,
	input wire logic [2:0] sfr_bit_sel,
	input wire logic       sfr_bit_val,
	input wire logic [7:0] sfr_rdata,
	input wire logic       vec_ack_tf0,
	input wire logic       vec_ack_tf1,
	input wire logic       vec_ack_ie0,
	input wire logic       vec_ack_ie1,
	input wire logic       timer_zero_overflow_flag,
	input wire logic       timer_one_overflow_flag,
	input wire logic       ext_irq_zero_pending,
	input wire logic       ext_irq_one_pending
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// -----------------------------------------------------------
	// control register access
	// -----------------------------------------------------------
	// a software set cannot be lost, unless a vector clears it
	a_bit_ovf_zero: assert property (
		sfr_bit_wr && ce && sfr_bit_sel == 3'h5 && sfr_bit_val && !vec_ack_tf0
		|=> timer_zero_overflow_flag) else $error("bit set of overflow zero lost");
	a_bit_ovf_one: assert property (
		sfr_bit_wr && ce && sfr_bit_sel == 3'h7 && sfr_bit_val && !vec_ack_tf1
		|=> timer_one_overflow_flag) else $error("bit set of overflow one lost");
	a_bit_pend_zero: assert property (
		sfr_bit_wr && ce && sfr_bit_sel == 3'h1 && sfr_bit_val && !vec_ack_ie0
		|=> ext_irq_zero_pending) else $error("bit set of pending zero lost");
	a_bit_pend_one: assert property (
		sfr_bit_wr && ce && sfr_bit_sel == 3'h3 && sfr_bit_val && !vec_ack_ie1
		|=> ext_irq_one_pending) else $error("bit set of pending one lost");
	a_byte_flags_set: assert property (
		sfr_wr && ce && sfr_addr == 8'h88 && (sfr_wdata & 8'hAA) == 8'hAA && !sfr_bit_wr
		&& !(vec_ack_tf0 || vec_ack_tf1 || vec_ack_ie0 || vec_ack_ie1)
		|=> timer_one_overflow_flag && timer_zero_overflow_flag
		&& ext_irq_one_pending && ext_irq_zero_pending) else $error("byte write of flags lost");
	// -----------------------------------------------------------
	// read data and clock enable
	// -----------------------------------------------------------
	a_rdata_holds: assert property (
		!(sfr_rd && ce) |=> $stable(sfr_rdata)) else $error("read data moved without a read");
	a_unmapped_zero: assert property (
		sfr_rd && ce && (sfr_addr < 8'h88 || sfr_addr > 8'h8D)
		|=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
	a_freeze_flags: assert property (
		!ce |=> $stable({timer_one_overflow_flag, timer_zero_overflow_flag,
		ext_irq_one_pending, ext_irq_zero_pending})) else $error("flags moved with ce low");
endmodule : dtc_timer_core_asserts

bind dtc_timer_core dtc_timer_core_asserts u_asserts (.clk, .resetn, .ce, .sfr_addr,
	.sfr_wr, .sfr_rd, .sfr_wdata, .sfr_bit_wr, .sfr_bit_sel, .sfr_bit_val, .sfr_rdata,
	.vec_ack_tf0, .vec_ack_tf1, .vec_ack_ie0, .vec_ack_ie1, .timer_zero_overflow_flag,
	.timer_one_overflow_flag, .ext_irq_zero_pending, .ext_irq_one_pending);

// ---- bench/dtc_pin_model.sv ----
// far-side pins: gate inputs, count pins and external prescaler clock
module dtc_pin_model (
	input  wire logic       clk,
	output logic      [4:0] pins
);
	timeunit 1ns;
	timeprecision 1ps;
	// lanes: 0,1 interrupt inputs (idle low), 2,3 count pins, 4 external clock
	// count lanes idle high so that only commanded falls are ever counted
	initial pins = 5'h1C;
	task automatic drive(input int i, input logic v);
		@(negedge clk);
		pins[i] = v;
	endtask : drive
	task automatic falls(input int i, input int n, input int half);
		repeat (n) begin
			drive(i, 1'b0);
			repeat (half) @(negedge clk);
			drive(i, 1'b1);
			repeat (half) @(negedge clk);
		end
	endtask : falls
endmodule : dtc_pin_model

// ---- bench/dtc_timer_core_test.sv ----
// self-checking bench for the dual timer/counter block
module dtc_timer_core_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk = 1'b0;
	logic       resetn = 1'b0;
	logic       ce = 1'b1;
	logic [7:0] sfr_addr = 8'h00;
	logic       sfr_wr = 1'b0;
	logic       sfr_rd = 1'b0;
	logic [7:0] sfr_wdata = 8'h00;
	logic       sfr_bit_wr = 1'b0;
	logic [2:0] sfr_bit_sel = 3'h0;
	logic       sfr_bit_val = 1'b0;
	logic [3:0] ack = 4'h0;
	logic [1:0] prescale_select = 2'h0;
	logic       sys_zero = 1'b0;
	logic       sys_one = 1'b0;
	logic [7:0] d;
	wire  [7:0] sfr_rdata;
	wire  [3:0] flags;
	wire  [4:0] pins;
	wire        t1_pulse;
	logic       pulse_seen = 1'b0;
	logic [1:0] pol = 2'h3;
	int         n_errors = 0;
	int         num_checks = 0;
	int         dv[4] = '{12, 4, 48, 8};

	always #4 clk = ~clk;
	// sticky capture, since the pulse stands for one cycle only
	always @(posedge clk) if (t1_pulse === 1'b1) pulse_seen <= 1'b1;

	dtc_pin_model pm (.clk(clk), .pins(pins));
	dtc_timer_core dut (
		.clk(clk), .resetn(resetn), .ce(ce), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_bit_wr(sfr_bit_wr),
		.sfr_bit_sel(sfr_bit_sel), .sfr_bit_val(sfr_bit_val), .sfr_rdata(sfr_rdata),
		.vec_ack_tf0(ack[2]), .vec_ack_tf1(ack[3]), .vec_ack_ie0(ack[0]),
		.vec_ack_ie1(ack[1]), .ext_irq_zero_input(pins[0]), .ext_irq_one_input(pins[1]),
		.count_pin_zero(pins[2]), .count_pin_one(pins[3]), .ext_clk_pin(pins[4]),
		.ext_irq_zero_polarity(pol[0]), .ext_irq_one_polarity(pol[1]),
		.prescale_select(prescale_select), .t0_sysclk_sel(sys_zero),
		.t1_sysclk_sel(sys_one), .timer_zero_overflow_flag(flags[2]),
		.timer_one_overflow_flag(flags[3]), .ext_irq_zero_pending(flags[0]),
		.ext_irq_one_pending(flags[1]), .timer_one_overflow_pulse(t1_pulse)
	);
	// -----------------------------------------------------------
	// bus cycles and comparisons
	// -----------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge clk);
		sfr_addr = a;
		sfr_wdata = v;
		sfr_wr = 1'b1;
		@(negedge clk);
		sfr_wr = 1'b0;
	endtask : wr
	task automatic bwr(input int b, input logic v);
		@(negedge clk);
		sfr_bit_sel = 3'(b);
		sfr_bit_val = v;
		sfr_bit_wr = 1'b1;
		@(negedge clk);
		sfr_bit_wr = 1'b0;
	endtask : bwr
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(negedge clk);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge clk);
		sfr_rd = 1'b0;
		v = sfr_rdata;
	endtask : rd
	task automatic vec(input int k);
		@(negedge clk);
		ack = 4'h1 << k;
		@(negedge clk);
		ack = 4'h0;
	endtask : vec
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic rng(input string nm, input logic [7:0] lo, input logic [7:0] hi,
		input logic [7:0] g);
		num_checks++;
		if ($isunknown(g) || g < lo || g > hi) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h..%h seen %h", nm, lo, hi, g);
		end
	endtask : rng
	task automatic wait_hi(input int k, input int lim);
		int n;
		n = 0;
		while (flags[k] !== 1'b1 && n < lim) begin
			@(negedge clk);
			n++;
		end
		chk("flag set", 8'h01, {7'h00, flags[k]});
	endtask : wait_hi
	// -----------------------------------------------------------
	// scenarios
	// -----------------------------------------------------------
	task automatic t_regs;
		rd(8'h88, d); chk("control reset", 8'h00, d);
		for (int i = 0; i < 5; i++) begin
			rd(8'h89 + 8'(i), d); chk("reset value", 8'h00, d);
			wr(8'h89 + 8'(i), 8'h5A ^ 8'(i));
			rd(8'h89 + 8'(i), d); chk("readback", 8'h5A ^ 8'(i), d);
		end
		wr(8'h90, 8'h77);
		rd(8'h90, d); chk("unmapped", 8'h00, d);
		ce = 1'b0;
		wr(8'h8A, 8'h33);
		ce = 1'b1;
		rd(8'h8A, d); chk("write with ce low", 8'h5B, d);
		// gate on, count pin idle: neither timer can move while the bits are set
		for (int b = 0; b < 8; b++) bwr(b, 1'b1);
		rd(8'h88, d); chk("bit writes", 8'hFF, d);
		wr(8'h88, 8'hAA);
		rd(8'h88, d); chk("byte write", 8'hAA, d);
		wr(8'h88, 8'h00);
	endtask : t_regs
	task automatic t_reload;
		wr(8'h89, 8'h02);
		wr(8'h8C, 8'h10);
		wr(8'h8A, 8'hFC);
		sys_zero = 1'b1;
		bwr(4, 1'b1);
		wait_hi(2, 20);
		bwr(4, 1'b0);
		rd(8'h8C, d); chk("reload kept", 8'h10, d);
		rd(8'h8A, d); rng("reloaded low", 8'h10, 8'h18, d);
		vec(2); chk("vector clear", 8'h00, {7'h00, flags[2]});
	endtask : t_reload
	task automatic t_gate;
		wr(8'h89, 8'h90);
		wr(8'h8B, 8'hF0);
		wr(8'h8D, 8'hFF);
		sys_one = 1'b1;
		bwr(6, 1'b1);
		repeat (30) @(negedge clk);
		rd(8'h8B, d); chk("gated off", 8'hF0, d);
		pm.drive(1, 1'b1);
		wait_hi(3, 40);
		bwr(7, 1'b0); chk("soft clear", 8'h00, {7'h00, flags[3]});
		chk("overflow pulse", 8'h01, {7'h00, pulse_seen});
		wr(8'h89, 8'h30);
		wr(8'h8B, 8'h00);
		repeat (20) @(negedge clk);
		rd(8'h8B, d); chk("mode inactive", 8'h00, d);
		bwr(6, 1'b0);
		pm.drive(1, 1'b0);
	endtask : t_gate
	task automatic t_count;
		wr(8'h89, 8'h55);
		for (int i = 0; i < 4; i++) wr(8'h8A + 8'(i), 8'h00);
		bwr(4, 1'b1);
		bwr(6, 1'b1);
		pm.falls(2, 5, 6);
		pm.falls(3, 3, 6);
		repeat (8) @(negedge clk);
		rd(8'h8A, d); chk("pin zero falls", 8'h05, d);
		rd(8'h8B, d); chk("pin one falls", 8'h03, d);
		bwr(4, 1'b0);
		bwr(6, 1'b0);
	endtask : t_count
	task automatic t_mode13;
		wr(8'h89, 8'h00);
		wr(8'h8C, 8'hFF);
		wr(8'h8A, 8'hFE);
		bwr(4, 1'b1);
		wait_hi(2, 20);
		bwr(4, 1'b0);
		bwr(5, 1'b0);
		rd(8'h8C, d); chk("13-bit wrap high", 8'h00, d);
		rd(8'h8A, d); rng("13-bit wrap low", 8'hE0, 8'hE8, d);
	endtask : t_mode13
	task automatic t_split;
		wr(8'h89, 8'h03);
		wr(8'h8A, 8'h40);
		wr(8'h8C, 8'hFC);
		bwr(6, 1'b1);
		wait_hi(3, 20);
		bwr(6, 1'b0);
		rd(8'h8A, d); chk("split low idle", 8'h40, d);
		chk("split zero flag", 8'h00, {7'h00, flags[2]});
		bwr(7, 1'b0);
	endtask : t_split
	task automatic t_presc;
		int e;
		wr(8'h89, 8'h01);
		sys_zero = 1'b0;
		for (int k = 0; k < 4; k++) begin
			prescale_select = 2'(k);
			wr(8'h8A, 8'h00);
			bwr(4, 1'b1);
			// the prescaler is never cleared, so its phase costs one count of slack
			if (k == 3) pm.falls(4, 24, 3);
			else repeat (240) @(negedge clk);
			bwr(4, 1'b0);
			e = (k == 3) ? 3 : 240 / dv[k];
			rd(8'h8A, d); rng("prescaled count", 8'(e - 1), 8'(e + 2), d);
		end
	endtask : t_presc
	task automatic t_irq(input int i);
		bwr(2 * i, 1'b1);
		bwr(2 * i + 1, 1'b0);
		pm.drive(i, 1'b1);
		wait_hi(i, 10);
		vec(i);
		repeat (8) @(negedge clk);
		chk("edge seen once", 8'h00, {7'h00, flags[i]});
		bwr(2 * i, 1'b0);
		wait_hi(i, 4);
		vec(i); chk("level kept", 8'h01, {7'h00, flags[i]});
		pm.drive(i, 1'b0);
		repeat (8) @(negedge clk);
		bwr(2 * i + 1, 1'b0); chk("soft clear", 8'h00, {7'h00, flags[i]});
		// active-low polarity: a low pin now counts as asserted
		pol[i] = 1'b0;
		wait_hi(i, 4);
		pol[i] = 1'b1;
		bwr(2 * i + 1, 1'b0); chk("polarity clear", 8'h00, {7'h00, flags[i]});
	endtask : t_irq

	task final_report;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : final_report

	initial begin
		repeat (8) @(negedge clk);
		resetn = 1'b1;
		repeat (4) @(negedge clk);
		t_regs;
		t_reload;
		t_gate;
		t_count;
		t_mode13;
		t_split;
		t_presc;
		t_irq(0);
		t_irq(1);
		final_report;
	end
	// about nine times the expected run
	initial begin
		#100000;
		n_errors++;
		final_report;
	end
endmodule : dtc_timer_core_test
